// ===== rtl/ccc_pkg.sv
// constants, state codes and carriers of the channel chaining controller
// assumes command and status words numbered bit 0 (msb) to bit 63
package ccc_pkg;

  // ******************************
  // command word layout
  // ******************************
  localparam int WORD_W    = 64;
  localparam int P_CMD_LO  = 0;
  localparam int P_CMD_HI  = 7;
  localparam int P_ADDR_LO = 8;
  localparam int P_ADDR_HI = 31;
  localparam int P_CD      = 32;
  localparam int P_CC      = 33;
  localparam int P_SLI     = 34;
  localparam int P_SK      = 35;
  localparam int P_CNT_LO  = 48;
  localparam int P_CNT_HI  = 63;

  // command code classes (low nibble of the code; read uses the low two bits)
  localparam logic [3:0] CMD_BRANCH   = 4'h8;
  localparam logic [3:0] CMD_SENSE    = 4'h4;
  localparam logic [3:0] CMD_READ_BWD = 4'hC;
  localparam logic [1:0] CMD_READ     = 2'h2;

  // ******************************
  // status word layout
  // ******************************
  localparam int P_DS_SM  = 33;
  localparam int P_DS_CE  = 36;
  localparam int P_DS_DE  = 37;
  localparam int P_WL     = 41;
  localparam int P_PC     = 42;
  localparam int P_CCK    = 43;

  localparam logic [1:0]  COND_NONE = 2'h0;
  localparam logic [1:0]  COND_IMM  = 2'h1;
  localparam logic [23:0] WORD_STEP = 24'h000008;

  // ******************************
  // apb register map
  // ******************************
  localparam logic [7:0] REG_CAW  = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_SWH  = 8'h0C;
  localparam logic [7:0] REG_SWL  = 8'h10;
  localparam logic [7:0] REG_NEXT = 8'h14;
  localparam int         CTRL_START = 0;

  // ******************************
  // types
  // ******************************
  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_FETCH  = 7'h02,
    ST_CHECK  = 7'h04,
    ST_ACTIVE = 7'h08,
    ST_WAIT_DE = 7'h10,
    ST_TERM   = 7'h20,
    ST_DONE   = 7'h40
  } ccc_state_t;

  typedef struct packed {
    logic svc_in;
    logic sts_in;
    logic ce;
    logic de;
    logic sm;
  } ccc_pins_t;

  typedef struct packed {
    logic cd;
    logic cc;
    logic length_suppress_flag;
    logic sk;
  } ccc_flags_t;

endpackage

// ===== rtl/ccc_chain_ctrl.sv
// channel program chaining controller: fetches command words, runs chaining
// decisions, drives the device terminate response and builds status words
// assumes apb master on clk, storage fetch port on clk, device pins async
// Operation
// - latch chain flags bits 32/33 as each new word is loaded
// - immediate first-word end writes status, code 01
// - terminate by command-out; active until channel end
// - wrong length sets status bit 41
// - command chain fetches after device end
// - data chain fetches at once on exhaustion
// - ignore service while new word is checked
// - zero count in new word: program check
// - immediate: chain only cc without cd
// - exhausted, device active: chain or terminate
// - ending status: chain, end, wrong length
// - branch word address becomes next fetch address
// - first word errors on branch terminate
// - branch ignores second word errors
// - branch to branch: program check, pending
// - branch as first word aborts, program check
// - skip flag blocks input storage writes
// - skip flag ignored for output
// - no storage or parity error while skipping
// - status modifier skips one command word
`timescale 1ns/1ns
module ccc_chain_ctrl
  import ccc_pkg::*;
#(
  parameter int ADDR_W = 24,
  parameter int CNT_W  = 16
)(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // apb slave
  input  wire logic [7:0]        paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // command word fetch port
  output logic                   fetch_req,
  output logic      [ADDR_W-1:0] fetch_addr,
  input  wire logic              fetch_ack,
  input  wire logic [0:63]       fetch_word,
  input  wire logic              fetch_err_first,
  input  wire logic              fetch_err_second,
  // data transfer port
  output logic                   data_strobe,
  output logic                   store_en,
  output logic      [ADDR_W-1:0] data_addr,
  input  wire logic              stor_err,
  input  wire logic              parity_err,
  output logic                   stor_err_rpt,
  output logic                   parity_err_rpt,
  // device side
  input  wire ccc_pins_t         dev_pins,
  input  wire logic              op_immediate,
  output logic                   cmd_out
);

  // ******************************
  // pin synchronisers
  // ******************************
  ccc_pins_t pins_s1;
  ccc_pins_t pins_s2;
  logic      svc_d;
  logic      sts_d;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pins_s1 <= '0;
      pins_s2 <= '0;
      svc_d   <= 1'b0;
      sts_d   <= 1'b0;
    end
    else
    begin
      pins_s1 <= dev_pins;
      pins_s2 <= pins_s1;
      svc_d   <= pins_s2.svc_in;
      sts_d   <= pins_s2.sts_in;
    end
  end
  logic svc_pulse;
  logic sts_pulse;
  assign svc_pulse = pins_s2.svc_in & ~svc_d;
  assign sts_pulse = pins_s2.sts_in & ~sts_d;

  // ******************************
  // state and decision
  // ******************************
  ccc_state_t       state;
  ccc_state_t       next_state;
  ccc_flags_t       flags;
  logic [0:63]      cw;
  logic             e_first;
  logic             e_second;
  logic [CNT_W-1:0] count;
  logic             dir_in;
  logic             first;
  logic             prev_branch;
  logic             start;
  logic             cw_branch;
  logic             exh;
  logic             load_cw;
  logic             take_branch;
  logic             cmd_chain;
  logic             set_wl;
  logic             set_pc;
  logic             set_cck;
  logic             imm_end;
  logic             fault_end;

  assign cw_branch = (cw[4:7] == CMD_BRANCH);
  assign exh       = (count == '0);

  always_comb
  begin
    next_state  = state;
    load_cw     = 1'b0;
    take_branch = 1'b0;
    cmd_chain   = 1'b0;
    set_wl      = 1'b0;
    set_pc      = 1'b0;
    set_cck     = 1'b0;
    imm_end     = 1'b0;
    fault_end   = 1'b0;
    case (state)
      ST_IDLE, ST_DONE:
        if (start)
          next_state = ST_FETCH;
      ST_FETCH:
        if (fetch_ack)
          next_state = ST_CHECK;
      ST_CHECK:
        if (e_first)
        begin
          set_cck   = 1'b1;
          fault_end = 1'b1;
        end
        else if (cw_branch && (first || prev_branch))
        begin
          set_pc    = 1'b1;
          fault_end = 1'b1;
        end
        else if (cw_branch)
        begin
          take_branch = 1'b1;
          next_state  = ST_FETCH;
        end
        else if (e_second)
        begin
          set_cck   = 1'b1;
          fault_end = 1'b1;
        end
        else if (cw[P_CNT_LO:P_CNT_HI] == '0)
        begin
          set_pc    = 1'b1;
          fault_end = 1'b1;
        end
        else
        begin
          load_cw    = 1'b1;
          next_state = ST_ACTIVE;
        end
      ST_ACTIVE:
        if (sts_pulse && pins_s2.ce)
        begin
          if (op_immediate)
            cmd_chain = flags.cc & ~flags.cd;
          else if (exh)
            cmd_chain = flags.cc & ~flags.cd;
          else
          begin
            cmd_chain = flags.cc & flags.length_suppress_flag & ~flags.cd;
            set_wl    = ~(flags.length_suppress_flag & ~flags.cd);
          end
          imm_end = op_immediate & first & ~cmd_chain;
          if (cmd_chain)
            next_state = pins_s2.de ? ST_FETCH : ST_WAIT_DE;
          else
            next_state = ST_DONE;
        end
        else if (exh && !op_immediate && flags.cd)
          next_state = ST_FETCH;
        else if (exh && !op_immediate && svc_pulse)
        begin
          // device still asks for data after the count ran out
          if (flags.cc && flags.length_suppress_flag)
            next_state = ST_WAIT_DE;
          else
          begin
            set_wl     = ~flags.length_suppress_flag;
            next_state = ST_TERM;
          end
        end
      ST_WAIT_DE:
        if (sts_pulse && pins_s2.de)
        begin
          cmd_chain  = 1'b1;
          next_state = ST_FETCH;
        end
      ST_TERM:
        if (sts_pulse && pins_s2.ce)
          next_state = ST_DONE;
      default:
        next_state = ST_IDLE;
    endcase
    if (fault_end)
      next_state = (flags.cd && !first) ? ST_TERM : ST_DONE;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // ******************************
  // command word capture and chain flags
  // ******************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cw       <= '0;
      e_first  <= 1'b0;
      e_second <= 1'b0;
    end
    else if (state == ST_FETCH && fetch_ack)
    begin
      cw       <= fetch_word;
      e_first  <= fetch_err_first;
      e_second <= fetch_err_second;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      flags  <= '0;
      dir_in <= 1'b0;
    end
    else if (load_cw)
    begin
      flags <= '{cd: cw[P_CD], cc: cw[P_CC], length_suppress_flag: cw[P_SLI], sk: cw[P_SK]};
      if (!(state == ST_CHECK && flags.cd && !first))
        dir_in <= (cw[6:7] == CMD_READ) || (cw[4:7] == CMD_SENSE) || (cw[4:7] == CMD_READ_BWD);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      first       <= 1'b0;
      prev_branch <= 1'b0;
    end
    else if (start && (state == ST_IDLE || state == ST_DONE))
    begin
      first       <= 1'b1;
      prev_branch <= 1'b0;
    end
    else if (take_branch)
      prev_branch <= 1'b1;
    else if (load_cw)
      prev_branch <= 1'b0;
    else if (state == ST_ACTIVE && next_state == ST_FETCH)
      first <= 1'b0;
    else if (state == ST_WAIT_DE && next_state == ST_FETCH)
      first <= 1'b0;
  end

  // ******************************
  // addresses and byte count
  // ******************************
  logic [ADDR_W-1:0] caw;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      fetch_addr <= '0;
    else if (start && (state == ST_IDLE || state == ST_DONE))
      fetch_addr <= caw;
    else if (take_branch)
      fetch_addr <= cw[P_ADDR_LO:P_ADDR_HI];
    else if (load_cw)
      fetch_addr <= fetch_addr + WORD_STEP;
    else if (cmd_chain && pins_s2.de && pins_s2.sm)
      fetch_addr <= fetch_addr + WORD_STEP;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      count     <= '0;
      data_addr <= '0;
    end
    else if (load_cw)
    begin
      count     <= cw[P_CNT_LO:P_CNT_HI];
      data_addr <= cw[P_ADDR_LO:P_ADDR_HI];
    end
    else if (state == ST_ACTIVE && svc_pulse && !exh)
    begin
      count     <= count - 1'b1;
      data_addr <= data_addr + 1'b1;
    end
  end

  // ******************************
  // data strobes and error masking
  // ******************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      data_strobe    <= 1'b0;
      store_en       <= 1'b0;
      stor_err_rpt   <= 1'b0;
      parity_err_rpt <= 1'b0;
    end
    else
    begin
      data_strobe    <= (state == ST_ACTIVE) && svc_pulse && !exh && next_state == ST_ACTIVE;
      store_en       <= (state == ST_ACTIVE) && svc_pulse && !exh && dir_in && !flags.sk;
      stor_err_rpt   <= stor_err && !(dir_in && flags.sk);
      parity_err_rpt <= parity_err && !(dir_in && flags.sk);
    end
  end

  // ******************************
  // terminate response
  // ******************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cmd_out <= 1'b0;
    else
      cmd_out <= svc_pulse && (state == ST_TERM || (state == ST_ACTIVE && next_state == ST_TERM));
  end

  // ******************************
  // status word and condition code
  // ******************************
  logic        sub_wl;
  logic        sub_pc;
  logic        sub_cck;
  logic [0:63] sw;
  logic [1:0]  cond_code;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sub_wl  <= 1'b0;
      sub_pc  <= 1'b0;
      sub_cck <= 1'b0;
    end
    else if (start && (state == ST_IDLE || state == ST_DONE))
    begin
      sub_wl  <= 1'b0;
      sub_pc  <= 1'b0;
      sub_cck <= 1'b0;
    end
    else
    begin
      sub_wl  <= sub_wl | set_wl;
      sub_pc  <= sub_pc | set_pc;
      sub_cck <= sub_cck | set_cck;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sw        <= '0;
      cond_code <= COND_NONE;
    end
    else if (next_state == ST_DONE && state != ST_DONE)
    begin
      sw                      <= '0;
      sw[P_ADDR_LO:P_ADDR_HI] <= fetch_addr;
      sw[P_DS_SM]             <= pins_s2.sm;
      sw[P_DS_CE]             <= pins_s2.ce;
      sw[P_DS_DE]             <= pins_s2.de;
      sw[P_WL]                <= sub_wl | set_wl;
      sw[P_PC]                <= sub_pc | set_pc;
      sw[P_CCK]               <= sub_cck | set_cck;
      sw[P_CNT_LO:P_CNT_HI]   <= count;
      cond_code               <= (imm_end || (first && set_pc)) ? COND_IMM : COND_NONE;
    end
  end

  // ******************************
  // apb slave
  // ******************************
  logic setup;
  logic wr_acc;
  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign pready = 1'b1;
  assign start  = wr_acc && paddr == REG_CTRL && pwdata[CTRL_START];

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      caw <= '0;
    else if (wr_acc && paddr == REG_CAW)
      caw <= pwdata[ADDR_W-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      pslverr <= 1'b0;
      if (paddr == REG_CAW)
        prdata <= 32'(caw);
      else if (paddr == REG_CTRL)
        prdata <= 32'(state != ST_IDLE && state != ST_DONE);
      else if (paddr == REG_STAT)
        prdata <= {16'h0000, flags, 2'b00, cond_code, 1'b0, state};
      else if (paddr == REG_SWH)
        prdata <= sw[0:31];
      else if (paddr == REG_SWL)
        prdata <= sw[32:63];
      else if (paddr == REG_NEXT)
        prdata <= 32'(fetch_addr);
      else
      begin
        prdata  <= '0;
        pslverr <= 1'b1;
      end
    end
  end

  assign fetch_req = (state == ST_FETCH);

  // ******************************
  // checks
  // ******************************
  a_imm_code: assert property (@(posedge clk) disable iff (!rst_n)
    imm_end |=> cond_code == COND_IMM && state == ST_DONE)
    else $error("immediate end without code 01");
  a_term_resp: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_TERM && svc_pulse |=> cmd_out)
    else $error("service-in not answered by command-out");
  a_wl_status: assert property (@(posedge clk) disable iff (!rst_n)
    set_wl && next_state == ST_DONE |=> sw[P_WL])
    else $error("wrong length bit missing");
  a_cc_waits: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_WAIT_DE && !(sts_pulse && pins_s2.de) |=> state == ST_WAIT_DE)
    else $error("command chain fetched before device end");
  a_dc_fetch: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_ACTIVE && exh && !sts_pulse && !op_immediate && flags.cd |=> fetch_req)
    else $error("data chain fetch delayed");
  a_no_strobe: assert property (@(posedge clk) disable iff (!rst_n)
    state != ST_ACTIVE |=> !data_strobe && !store_en)
    else $error("service taken outside active transfer");
  a_zero_cnt: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_CHECK && !e_first && !cw_branch && !e_second && cw[P_CNT_LO:P_CNT_HI] == '0
    |=> state != ST_ACTIVE ##1 sub_pc)
    else $error("zero count not a program check");
  a_branch_addr: assert property (@(posedge clk) disable iff (!rst_n)
    take_branch |=> fetch_req && fetch_addr == $past(cw[P_ADDR_LO:P_ADDR_HI]))
    else $error("branch address not used");
  a_skip_store: assert property (@(posedge clk) disable iff (!rst_n)
    flags.sk && dir_in |=> !store_en && !stor_err_rpt && !parity_err_rpt)
    else $error("skip flag did not block storage");
  a_flags_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !load_cw |=> $stable(flags))
    else $error("flags changed mid operation");

endmodule

// ===== tb/ccc_dev_model.sv
// peripheral control unit model driving the device pins of the channel
// assumes the channel samples the pins on clk through its own synchronisers
`timescale 1ns/1ns
module ccc_dev_model
  import ccc_pkg::*;
(
  // clock
  input  wire logic clk,
  // channel side
  input  wire logic cmd_out,
  output ccc_pins_t dev_pins
);
  // ******************************
  // pin sequences
  // ******************************
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one byte request, long enough for the synchronisers
  task automatic service();
    dev_pins.svc_in <= 1'b1;
    hold(4);
    dev_pins.svc_in <= 1'b0;
    hold(8);
  endtask

  // status lines settle around the strobe, then scramble
  task automatic status(input logic ce, input logic de, input logic sm);
    dev_pins.ce <= ce;
    dev_pins.de <= de;
    dev_pins.sm <= sm;
    hold(2);
    dev_pins.sts_in <= 1'b1;
    hold(4);
    dev_pins.sts_in <= 1'b0;
    hold(2);
    dev_pins.ce <= !ce;
    dev_pins.de <= !de;
    dev_pins.sm <= !sm;
    hold(6);
  endtask

  // ******************************
  // terminate response
  // ******************************
  initial
  begin
    dev_pins = '0;
    forever
    begin
      @(posedge clk);
      if (cmd_out === 1'b1)
        status(1'b1, 1'b1, 1'b0);
    end
  end
endmodule

// ===== tb/tb_ccc_chain_ctrl.sv
// self-checking bench of the channel chaining controller
// assumes zero-wait apb; storage answered here, device by ccc_dev_model
`timescale 1ns/1ns
module tb_ccc_chain_ctrl
  import ccc_pkg::*;
;
  localparam logic [3:0] F_CD   = 4'h8;
  localparam logic [3:0] F_CC   = 4'h4;
  localparam logic [3:0] F_SLI  = 4'h2;
  localparam logic [3:0] F_SK   = 4'h1;
  localparam logic [7:0] OP_RD  = 8'h02;
  localparam logic [7:0] OP_WR  = 8'h01;
  localparam logic [7:0] OP_BR  = 8'h08;
  localparam logic [7:0] OP_IMM = 8'h03;

  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, st, sl;
  logic        fetch_req, fetch_ack, fetch_err_first, fetch_err_second, err;
  logic [23:0] fetch_addr, data_addr, e2_at;
  logic [0:63] fetch_word;
  logic        data_strobe, store_en, stor_err, parity_err;
  logic        stor_err_rpt, parity_err_rpt, op_immediate, cmd_out;
  ccc_pins_t   dev_pins;
  logic [0:63] mem [logic [23:0]];
  logic [23:0] fq[$];
  int          n_mismatch, tests_run, cycles, n_cmd, n_store, n_strobe, n_rpt;

  ccc_chain_ctrl u_ccc_chain_ctrl (
    .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_ack(fetch_ack), .fetch_word(fetch_word), .fetch_err_first(fetch_err_first),
    .fetch_err_second(fetch_err_second), .data_strobe(data_strobe), .store_en(store_en),
    .data_addr(data_addr), .stor_err(stor_err), .parity_err(parity_err),
    .stor_err_rpt(stor_err_rpt), .parity_err_rpt(parity_err_rpt),
    .dev_pins(dev_pins), .op_immediate(op_immediate), .cmd_out(cmd_out)
  );

  ccc_dev_model u_ccc_dev_model (.clk(clk), .cmd_out(cmd_out), .dev_pins(dev_pins));

  // ******************************
  // clock, storage port, watchers
  // ******************************
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_mismatch++;
      wrap_up();
    end
    n_cmd    += int'(cmd_out === 1'b1);
    n_store  += int'(store_en === 1'b1);
    n_strobe += int'(data_strobe === 1'b1);
    n_rpt    += int'(stor_err_rpt === 1'b1 || parity_err_rpt === 1'b1);
    fetch_ack <= 1'b0;
    if (fetch_req === 1'b1 && !fetch_ack)
    begin
      fetch_ack        <= 1'b1;
      fetch_word       <= mem.exists(fetch_addr) ? mem[fetch_addr] : '0;
      fetch_err_second <= (fetch_addr == e2_at);
      fq.push_back(fetch_addr);
    end
  end

  // ******************************
  // tasks
  // ******************************
  function automatic logic [0:63] mk(input logic [7:0] c, input logic [23:0] a,
                                     input logic [3:0] f, input logic [15:0] n);
    mk = {c, a, f, 12'h000, n};
  endfunction

  task automatic wrap_up();
    if (n_mismatch == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic go(input logic [23:0] caw);
    n_cmd    = 0;
    n_store  = 0;
    n_strobe = 0;
    n_rpt    = 0;
    fq.delete();
    apb(1'b1, REG_CAW, {8'h00, caw});
    apb(1'b1, REG_CTRL, 32'h00000001);
    repeat (8) @(posedge clk);
  endtask

  task automatic fin();
    do
      apb(1'b0, REG_STAT, 32'h00000000);
    while (q[6] !== 1'b1);
    st = q;
    apb(1'b0, REG_SWL, 32'h00000000);
    sl = q;
  endtask

  task automatic svc(input int n);
    repeat (n) u_ccc_dev_model.service();
  endtask

  task automatic sts(input logic sm);
    u_ccc_dev_model.status(1'b1, 1'b1, sm);
  endtask

  // ******************************
  // main sequence
  // ******************************
  initial
  begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; fetch_ack = 1'b0; fetch_word = '0; fetch_err_first = 1'b0;
    fetch_err_second = 1'b0; stor_err = 1'b0; parity_err = 1'b0; op_immediate = 1'b0;
    e2_at = 24'hFFFFFF; n_mismatch = 0; tests_run = 0; cycles = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, REG_STAT, 32'h0);
    chk(q, 32'h00000001);
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(err), 32'h1);
    chk(q, 32'h0);
    // exhausted count, device still asking: terminate, length flag unless suppressed
    for (int i = 0; i < 2; i++)
    begin
      mem[24'h000100] = mk(OP_RD, 24'h001000, (i == 1) ? F_SLI : 4'h0, 16'h0002);
      go(24'h000100);
      svc(3);
      fin();
      chk(32'(n_cmd), 32'h1);
      chk(32'(sl[22]), 32'(i == 0));
      chk(32'(n_store), 32'h2);
    end
    // ending status with count left: end with wrong length
    mem[24'h000180] = mk(OP_RD, 24'h001000, 4'h0, 16'h0004);
    go(24'h000180);
    svc(1);
    sts(1'b0);
    fin();
    chk(32'(sl[22]), 32'h1);
    chk({16'h0, sl[15:0]}, 32'h00000003);
    chk(32'(n_cmd), 32'h0);
    // command chain with status modifier skips one word
    mem[24'h000200] = mk(OP_RD, 24'h001000, F_CC, 16'h0001);
    mem[24'h000210] = mk(OP_RD, 24'h001100, 4'h0, 16'h0001);
    go(24'h000200);
    apb(1'b0, REG_STAT, 32'h0);
    chk(32'(q[15:12]), 32'(F_CC));
    svc(1);
    chk(32'(fq.size()), 32'h1);
    sts(1'b1);
    svc(1);
    sts(1'b0);
    fin();
    chk(32'(fq.size()), 32'h2);
    chk(32'(fq[1]), 32'h00000210);
    // chain into a branch whose second word is faulty
    mem[24'h000300] = mk(OP_RD, 24'h001000, F_CC, 16'h0001);
    mem[24'h000308] = mk(OP_BR, 24'h000400, 4'h0, 16'h0000);
    mem[24'h000400] = mk(OP_RD, 24'h001200, 4'h0, 16'h0001);
    e2_at = 24'h000308;
    go(24'h000300);
    svc(1);
    sts(1'b0);
    svc(1);
    sts(1'b0);
    fin();
    e2_at = 24'hFFFFFF;
    chk(32'(fq[2]), 32'h00000400);
    chk(32'(sl[20]), 32'h0);
    chk(32'(sl[22:21]), 32'h0);
    // branch to branch, then branch as first word
    mem[24'h000500] = mk(OP_RD, 24'h001000, F_CC, 16'h0001);
    mem[24'h000508] = mk(OP_BR, 24'h000600, 4'h0, 16'h0000);
    mem[24'h000600] = mk(OP_BR, 24'h000700, 4'h0, 16'h0000);
    go(24'h000500);
    svc(1);
    sts(1'b0);
    fin();
    chk(32'(sl[21]), 32'h1);
    go(24'h000600);
    fin();
    chk(32'(sl[21]), 32'h1);
    chk(32'(fq.size()), 32'h1);
    fetch_err_first <= 1'b1;
    go(24'h000600);
    fin();
    fetch_err_first <= 1'b0;
    chk(32'(sl[21:20]), 32'h1);
    // data chain fetches before the device is done; then a zero count
    mem[24'h000800] = mk(OP_RD, 24'h001000, F_CD, 16'h0001);
    mem[24'h000808] = mk(OP_WR, 24'h002000, 4'h0, 16'h0002);
    go(24'h000800);
    svc(1);
    chk(32'(fq.size()), 32'h2);
    svc(2);
    sts(1'b0);
    fin();
    chk(32'(n_store), 32'h3);
    chk(32'(sl[22]), 32'h0);
    mem[24'h000900] = mk(OP_RD, 24'h001000, F_CD, 16'h0001);
    mem[24'h000908] = mk(OP_RD, 24'h002000, 4'h0, 16'h0000);
    go(24'h000900);
    svc(2);
    fin();
    chk(32'(sl[21]), 32'h1);
    chk(32'(n_cmd), 32'h1);
    // skip flag on input and on output, with errors raised by the datapath
    mem[24'h000A00] = mk(OP_RD, 24'h001000, F_SK, 16'h0002);
    go(24'h000A00);
    stor_err   <= 1'b1;
    parity_err <= 1'b1;
    svc(2);
    sts(1'b0);
    fin();
    chk(32'(n_store), 32'h0);
    chk(32'(n_strobe), 32'h2);
    chk(32'(n_rpt), 32'h0);
    mem[24'h000B00] = mk(OP_WR, 24'h001000, F_SK, 16'h0002);
    go(24'h000B00);
    svc(2);
    sts(1'b0);
    fin();
    chk(32'(n_strobe), 32'h2);
    chk(32'(n_rpt != 0), 32'h1);
    stor_err   <= 1'b0;
    parity_err <= 1'b0;
    // immediate first word, plain and with both chain flags
    op_immediate <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      mem[24'h000C00] = mk(OP_IMM, 24'h000000, (i == 1) ? (F_CD | F_CC) : 4'h0, 16'h0001);
      go(24'h000C00);
      sts(1'b0);
      fin();
      chk(32'(st[9:8]), 32'(COND_IMM));
      chk(32'(fq.size()), 32'h1);
    end
    op_immediate <= 1'b0;
    wrap_up();
  end
endmodule
